/* shared/tbc_pkg.sv */
// Purpose: Constants for the type-B timer control and status block.
// Assumes: 8-bit registers, one per 32-bit Avalon word.
// Notes:   Byte address of a register is four times its index.
package tbc_pkg;

  // ==========================================================
  // Register indices
  // ==========================================================
  localparam logic [2:0] TBC_IDX_CONTROL_A   = 3'h0;
  localparam logic [2:0] TBC_IDX_CONTROL_B   = 3'h1;
  localparam logic [2:0] TBC_IDX_EVENT_CTRL  = 3'h4;
  localparam logic [2:0] TBC_IDX_INT_CTRL    = 3'h5;
  localparam logic [2:0] TBC_IDX_INT_FLAGS   = 3'h6;
  localparam logic [2:0] TBC_IDX_RUN_STATUS  = 3'h7;
  localparam logic [7:0] TBC_RESET_VALUE     = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int TBC_BIT_ENABLE       = 0;
  localparam int TBC_BIT_CLOCK_SELECT_LO    = 1;
  localparam int TBC_BIT_SYNC_RESTART = 4;
  localparam int TBC_BIT_STANDBY_RUN  = 6;
  localparam int TBC_BIT_MODE_LO      = 0;
  localparam int TBC_BIT_OUT_ENABLE   = 4;
  localparam int TBC_BIT_OUT_INIT     = 5;
  localparam int TBC_BIT_OUTPUT_A     = 6;
  localparam int TBC_BIT_CAPTURE_FLAG_EV_EN   = 0;
  localparam int TBC_BIT_EDGE         = 4;
  localparam int TBC_BIT_FILTER       = 6;
  localparam int TBC_BIT_FLAG         = 0;
  localparam int TBC_BIT_RUNNING      = 0;

  // Writable bit masks per control register
  localparam logic [7:0] TBC_MASK_CONTROL_A  = 8'h57;
  localparam logic [7:0] TBC_MASK_CONTROL_B  = 8'h77;
  localparam logic [7:0] TBC_MASK_EVENT_CTRL = 8'h51;
  localparam logic [7:0] TBC_MASK_INT_CTRL   = 8'h01;

  // ==========================================================
  // Clock select codes and filter length
  // ==========================================================
  localparam logic [1:0] TBC_PERIPHERAL_CLOCK      = 2'h0;
  localparam logic [1:0] TBC_PERIPHERAL_CLOCK_DIV2 = 2'h1;
  localparam logic [1:0] TBC_CLK_TYPE_A   = 2'h2;
  localparam int         TBC_FILTER_LEN   = 4;

  // Count modes
  typedef enum logic [2:0] {
    TBC_MODE_PERIODIC  = 3'h0,
    TBC_MODE_TIMEOUT   = 3'h1,
    TBC_MODE_CAPTURE   = 3'h2,
    TBC_MODE_FREQ      = 3'h3,
    TBC_MODE_PULSE     = 3'h4,
    TBC_MODE_FREQ_PW   = 3'h5,
    TBC_MODE_SINGLE    = 3'h6,
    TBC_MODE_PWM8      = 3'h7
  } tbc_mode_t;

endpackage

/* verilog/tbc_timer.sv */
// Purpose: Control, event and status logic of a 16-bit capture timer.
// Assumes: Event input is asynchronous; top value comes from outside.
// Notes:   Registers sit behind an Avalon-MM slave with waitrequest.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module tbc_timer
  import tbc_pkg::*;
(
  input  wire logic        i_sys_clk,          // System clock
  input  wire logic        i_rst_b,            // Asynchronous reset, low active
  input  wire logic        i_clk_en,           // Freezes all state when low
  input  wire logic [4:0]  i_avs_address,      // Byte address
  input  wire logic        i_avs_read,         // Read request
  input  wire logic        i_avs_write,        // Write request
  input  wire logic [31:0] i_avs_writedata,    // Write data
  output logic      [31:0] o_avs_readdata,     // Read data
  output logic             o_avs_waitrequest,  // Stall
  input  wire logic        i_event,            // Capture event input
  input  wire logic        i_standby,          // Standby sleep active
  input  wire logic        i_ta_tick,          // Companion timer clock tick
  input  wire logic        i_ta_restart,       // Companion timer restart
  input  wire logic [15:0] i_top_value,        // Compare / top value
  input  wire logic        i_capture_read,     // Capture register read
  output logic      [15:0] o_count,            // Counter value
  output logic      [15:0] o_capture_value,    // Captured counter value
  output logic             o_capture_load,     // Capture register loaded
  output logic             o_cc_out,           // Compare/capture output
  output logic             o_irq,              // Interrupt request
  output logic             o_event_strobe      // One-cycle event output
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [7:0]  control_a;        // Clock, enable, sync, standby
  logic [7:0]  control_b;        // Mode and output control
  logic [7:0]  event_control;    // Filter, edge, event enable
  logic [7:0]  interrupt_control; // Interrupt enable
  logic        capture_flag;     // Sticky capture flag
  logic        running;          // Counter is running
  logic        bus_ack;          // Answer phase of a bus access
  logic [2:0]  reg_idx;          // Register index from address
  logic        wr_take;          // Write takes effect this edge
  logic [1:0]  ev_sync;          // Event synchroniser
  logic [TBC_FILTER_LEN-1:0] ev_hist; // Filter sample history
  logic        ev_level;         // Level fed to edge detector
  logic        ev_prev;          // Previous level for edge detect
  logic        div2;             // Half-rate toggle
  logic        tick;             // Count tick this cycle
  logic        halted;           // Standby without standby-run
  logic        rise;             // Rising event edge
  logic        fall;             // Falling event edge
  logic        sel_edge;         // Selected edge
  logic        opp_edge;         // Opposite edge
  logic        at_top;           // Counter at top on a tick
  logic        set_flag;         // Flag set condition
  logic        do_restart;       // Clear and restart counter
  logic        do_start;         // Start counter
  logic        do_stop;          // Stop counter
  logic        do_capture;       // Copy counter to capture
  logic        ss_out;           // Single-shot output level
  logic        pwm_out;          // PWM output level
  logic [1:0]  fpw_phase;        // Combined mode progress
  logic        enabled;          // Enable bit
  tbc_mode_t   mode;             // Current count mode
  logic [1:0]  clock_select;     // Clock select field

  assign enabled      = control_a[TBC_BIT_ENABLE];
  assign clock_select = control_a[TBC_BIT_CLOCK_SELECT_LO +: 2];
  assign mode         = tbc_mode_t'(control_b[TBC_BIT_MODE_LO +: 3]);
  assign reg_idx      = i_avs_address[4:2];
  assign wr_take      = i_avs_write & bus_ack;

  // ==========================================================
  // Avalon-MM slave
  // ==========================================================
  // Requests wait one cycle; the answer comes at the second edge
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_ack;

  // Answer phase toggles in for one cycle per request
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      bus_ack <= 1'b0;
    else if (i_clk_en)
      bus_ack <= (i_avs_read | i_avs_write) & ~bus_ack;
  end

  // Read data captured during the wait cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_clk_en && i_avs_read && !bus_ack)
    begin
      if (reg_idx == TBC_IDX_CONTROL_A)
        o_avs_readdata <= {24'h000000, control_a};
      else if (reg_idx == TBC_IDX_CONTROL_B)
        o_avs_readdata <= {24'h000000, control_b};
      else if (reg_idx == TBC_IDX_EVENT_CTRL)
        o_avs_readdata <= {24'h000000, event_control};
      else if (reg_idx == TBC_IDX_INT_CTRL)
        o_avs_readdata <= {24'h000000, interrupt_control};
      else if (reg_idx == TBC_IDX_INT_FLAGS)
        o_avs_readdata <= {31'h00000000, capture_flag};
      else if (reg_idx == TBC_IDX_RUN_STATUS)
        o_avs_readdata <= {31'h00000000, running};
      else
        o_avs_readdata <= 32'h0000_0000;      // Unmapped reads zero
    end
  end

  // Control registers; status registers are not written here
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      control_a         <= TBC_RESET_VALUE;
      control_b         <= TBC_RESET_VALUE;
      event_control     <= TBC_RESET_VALUE;
      interrupt_control <= TBC_RESET_VALUE;
    end
    else if (i_clk_en && wr_take)
    begin
      if (reg_idx == TBC_IDX_CONTROL_A)
        control_a <= i_avs_writedata[7:0] & TBC_MASK_CONTROL_A;
      else if (reg_idx == TBC_IDX_CONTROL_B)
        control_b <= i_avs_writedata[7:0] & TBC_MASK_CONTROL_B;
      else if (reg_idx == TBC_IDX_EVENT_CTRL)
        event_control <= i_avs_writedata[7:0] & TBC_MASK_EVENT_CTRL;
      else if (reg_idx == TBC_IDX_INT_CTRL)
        interrupt_control <= i_avs_writedata[7:0] & TBC_MASK_INT_CTRL;
    end
  end

  // ==========================================================
  // Event input path
  // ==========================================================
  // Two-stage synchroniser, then the sample history
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ev_sync <= 2'h0;
      ev_hist <= '0;
    end
    else if (i_clk_en)
    begin
      ev_sync <= {ev_sync[0], i_event};
      ev_hist <= {ev_hist[TBC_FILTER_LEN-2:0], ev_sync[1]};
    end
  end

  // Filtered or direct level, and its previous value
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ev_level <= 1'b0;
      ev_prev  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      ev_prev <= ev_level;
      if (!event_control[TBC_BIT_FILTER])
        ev_level <= ev_sync[1];
      else if (&ev_hist || ~|ev_hist)
        ev_level <= ev_hist[0];
    end
  end

  // Edges only count while events are enabled
  assign rise = event_control[TBC_BIT_CAPTURE_FLAG_EV_EN] & ev_level & ~ev_prev;
  assign fall = event_control[TBC_BIT_CAPTURE_FLAG_EV_EN] & ~ev_level & ev_prev;
  assign sel_edge = event_control[TBC_BIT_EDGE] ? fall : rise;
  assign opp_edge = event_control[TBC_BIT_EDGE] ? rise : fall;

  // ==========================================================
  // Count clock selection
  // ==========================================================
  // Half-rate toggle for the divided peripheral clock
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      div2 <= 1'b0;
    else if (i_clk_en)
      div2 <= ~div2;
  end

  // Standby halts unless standby-run is set or type-A clock is used
  assign halted = i_standby & ~control_a[TBC_BIT_STANDBY_RUN] &
                  (clock_select != TBC_CLK_TYPE_A);

  // Tick per selected source; reserved code never ticks
  always_comb
  begin
    case (clock_select)
      TBC_PERIPHERAL_CLOCK:      tick = 1'b1;
      TBC_PERIPHERAL_CLOCK_DIV2: tick = div2;
      TBC_CLK_TYPE_A:   tick = i_ta_tick;
      default:          tick = 1'b0;
    endcase
    tick = tick & enabled & running & ~halted;
  end

  // ==========================================================
  // Mode decode
  // ==========================================================
  assign at_top = tick && (mode == TBC_MODE_PWM8 ? o_count[7:0] == i_top_value[7:0]
                                                 : o_count == i_top_value);

  // Per-mode event actions and flag conditions
  always_comb
  begin
    do_restart = 1'b0;
    do_start   = 1'b0;
    do_stop    = 1'b0;
    do_capture = 1'b0;
    set_flag   = 1'b0;
    case (mode)
      TBC_MODE_PERIODIC:                              // Events ignored
        set_flag = at_top;
      TBC_MODE_TIMEOUT:
      begin
        do_start = sel_edge;
        do_stop  = opp_edge;
        set_flag = at_top;
      end
      TBC_MODE_CAPTURE:
      begin
        do_capture = sel_edge;
        set_flag   = sel_edge;
      end
      TBC_MODE_FREQ:
      begin
        do_capture = sel_edge;
        do_restart = sel_edge;
        set_flag   = sel_edge;
      end
      TBC_MODE_PULSE:
      begin
        do_restart = sel_edge;
        do_capture = opp_edge;
        set_flag   = opp_edge;
      end
      TBC_MODE_FREQ_PW:
      begin
        do_restart = sel_edge && fpw_phase == 2'h0;
        do_capture = opp_edge && fpw_phase == 2'h1;
        do_stop    = sel_edge && fpw_phase == 2'h2;
        set_flag   = do_stop;
      end
      TBC_MODE_SINGLE:
      begin
        do_start = sel_edge & ~running;
        do_stop  = at_top;
        set_flag = at_top;
      end
      default:                                        // 8-bit PWM
        set_flag = tick && o_count[7:0] == i_top_value[15:8];
    endcase
  end

  // Combined mode progress: restart, capture, stop
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      fpw_phase <= 2'h0;
    else if (i_clk_en)
    begin
      if (!enabled || mode != TBC_MODE_FREQ_PW)
        fpw_phase <= 2'h0;
      else if (do_restart)
        fpw_phase <= 2'h1;
      else if (do_capture)
        fpw_phase <= 2'h2;
      else if (do_stop)
        fpw_phase <= 2'h0;
    end
  end

  // ==========================================================
  // Run state and counter
  // ==========================================================
  // Free-running modes run whenever enabled; others follow events
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      running <= 1'b0;
    else if (i_clk_en)
    begin
      if (!enabled)
        running <= 1'b0;
      else if (do_stop)
        running <= 1'b0;
      else if (do_start || do_restart)
        running <= 1'b1;
      else if (mode inside {TBC_MODE_PERIODIC, TBC_MODE_CAPTURE,
                             TBC_MODE_FREQ, TBC_MODE_PULSE, TBC_MODE_PWM8})
        running <= 1'b1;
    end
  end

  // Counter: restart wins, then wrap at top, then advance
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_count <= 16'h0000;
    else if (i_clk_en)
    begin
      if (do_restart)
        o_count <= 16'h0000;
      else if (control_a[TBC_BIT_SYNC_RESTART] && i_ta_restart && enabled)
        o_count <= 16'h0000;
      else if (at_top)
        o_count <= 16'h0000;
      else if (tick)
        o_count <= o_count + 16'h0001;
    end
  end

  // Capture register load
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_capture_value <= 16'h0000;
      o_capture_load  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_capture_load <= do_capture;
      if (do_capture)
        o_capture_value <= o_count;
    end
  end

  // ==========================================================
  // Flag, interrupt and event strobe
  // ==========================================================
  // Set wins over either clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      capture_flag <= 1'b0;
    else if (i_clk_en)
    begin
      if (set_flag)
        capture_flag <= 1'b1;
      else if (wr_take && reg_idx == TBC_IDX_INT_FLAGS &&
               i_avs_writedata[TBC_BIT_FLAG])
        capture_flag <= 1'b0;
      else if (i_capture_read && mode inside {TBC_MODE_CAPTURE, TBC_MODE_FREQ,
                                              TBC_MODE_PULSE, TBC_MODE_FREQ_PW})
        capture_flag <= 1'b0;
    end
  end

  // Request follows flag and enable as a level
  assign o_irq = capture_flag & interrupt_control[TBC_BIT_FLAG];

  // Strobe for each flag set condition
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_event_strobe <= 1'b0;
    else if (i_clk_en)
      o_event_strobe <= set_flag;
  end

  // ==========================================================
  // Output pin logic
  // ==========================================================
  // Single-shot level: rises at start or event, falls at stop
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ss_out <= 1'b0;
    else if (i_clk_en)
    begin
      if (!enabled || do_stop)
        ss_out <= 1'b0;
      else if (control_b[TBC_BIT_OUTPUT_A] && do_start)
        ss_out <= 1'b1;
      else if (!control_b[TBC_BIT_OUTPUT_A] && running)
        ss_out <= 1'b1;
    end
  end

  // PWM level: high from bottom until the high compare byte
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pwm_out <= 1'b0;
    else if (i_clk_en)
    begin
      if (!enabled || i_top_value[15:8] == 8'h00 || i_top_value[7:0] == 8'h00)
        pwm_out <= 1'b0;
      else if (set_flag)
        pwm_out <= 1'b0;
      else if (tick && o_count[7:0] == 8'h00)
        pwm_out <= 1'b1;
    end
  end

  // Final pin value per mode, forced low when the output enable bit is clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_cc_out <= 1'b0;
    else if (i_clk_en)
    begin
      if (!control_b[TBC_BIT_OUT_ENABLE])
        o_cc_out <= 1'b0;
      else if (mode == TBC_MODE_SINGLE)
        o_cc_out <= ss_out;
      else if (mode == TBC_MODE_PWM8)
        o_cc_out <= pwm_out;
      else
        o_cc_out <= control_b[TBC_BIT_OUT_INIT];
    end
  end

endmodule // tbc_timer

/* tb/tbc_sva.sv */
// Purpose: Port assertions for the type-B timer block.
// Assumes: One clock domain; the bus answers after one wait cycle.
// Notes:   Bound to tbc_timer after the module.
`timescale 1ns/1ps
module tbc_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_clk_en,
  input wire logic [4:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_capture_read,
  input wire logic        o_irq,
  input wire logic        o_event_strobe
);
  // ============================================
  // Bus and flag properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic req; // Any bus request pending
  assign req = i_avs_read | i_avs_write;
  sequence s_wait; req && o_avs_waitrequest && i_clk_en; endsequence
  sequence s_done; req && !o_avs_waitrequest; endsequence
  property p_wait_first; $rose(req) |-> o_avs_waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("request not stalled");
  property p_wait_one; s_wait |=> !o_avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("stall too long");
  property p_idle; !req |-> !o_avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("stall while idle");
  property p_upper; s_done ##0 i_avs_read |-> o_avs_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_hole;
    s_done ##0 (i_avs_read && i_avs_address[4:3] == 2'h1) |-> o_avs_readdata == 32'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_run_ro;
    s_done ##0 (i_avs_read && i_avs_address == 5'h1c) |-> o_avs_readdata[7:1] == 7'h0;
  endproperty
  a_run_ro: assert property (p_run_ro) else $error("status spare bits set");
  property p_strobe; o_event_strobe |=> !o_event_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  property p_irq_hold; o_irq && !i_avs_write && !i_capture_read |=> o_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped");
  property p_w1c;
    s_done ##0 (i_avs_write && i_avs_address == 5'h18 && i_avs_writedata[0])
      |=> !o_irq || o_event_strobe;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
endmodule // tbc_sva

bind tbc_timer tbc_sva u_tbc_sva (.i_sys_clk, .i_rst_b, .i_clk_en, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
  .i_capture_read, .o_irq, .o_event_strobe);

/* tb/tbc_event_src.sv */
// Purpose: Event routing network in front of the capture input.
// Assumes: Bench sets the wanted level at rising edges.
// Notes:   Slow path adds two cycles of routing delay.
`timescale 1ns/1ps
module tbc_event_src (
  input  wire logic i_sys_clk, // System clock
  input  wire logic i_level,   // Wanted event level
  input  wire logic i_slow,    // Select slow route
  output logic      o_event    // Event line to the timer
);
  // ============================================
  // Routing delay line
  logic [2:0] pipe = 3'h0; // Level history
  always_ff @(posedge i_sys_clk)
  begin
    pipe <= {pipe[1:0], i_level};
  end
  assign o_event = i_slow ? pipe[2] : pipe[0];
endmodule // tbc_event_src

/* tb/timer_b_control_status_tb.sv */
// Purpose: Self-checking bench for the type-B timer block.
// Assumes: Bus answers after one wait cycle; event model in front.
// Notes:   Plain register cases sit in a table.
`timescale 1ns/1ps
module timer_b_control_status_tb;
  // ============================================
  // Stimulus and observed signals
  logic        clk = 1'h0, rst_b = 1'h0, rd = 1'h0, wr = 1'h0, cap_rd = 1'h0;
  logic        ev_lvl = 1'h0, slow = 1'h0, stby = 1'h0, tick = 1'h0, rstrt = 1'h0;
  logic [4:0]  adr = 5'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [15:0] top = 16'hffff, c0, cnt, capv;
  logic        wq, irq, ld, cc, stb, ev;
  logic [2:0]  sig; // Watched pulses
  int          miscompares = 0, n_tests = 0, cyc = 0;
  logic [20:0] rows [8] = '{{5'h00, 8'hff, 8'h57}, {5'h04, 8'hff, 8'h77},
    {5'h10, 8'hff, 8'h51}, {5'h14, 8'hff, 8'h01}, {5'h08, 8'hff, 8'h00},
    {5'h00, 8'h00, 8'h00}, {5'h04, 8'h00, 8'h00}, {5'h1c, 8'hff, 8'h00}};
  assign sig = {stb, ld, irq};
  always #5 clk = ~clk;
  tbc_event_src u_tbc_event_src (.i_sys_clk(clk), .i_level(ev_lvl), .i_slow(slow),
    .o_event(ev));
  tbc_timer u_tbc_timer (.i_sys_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'h1),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_event(ev), .i_standby(stby),
    .i_ta_tick(tick), .i_ta_restart(rstrt), .i_top_value(top), .i_capture_read(cap_rd),
    .o_count(cnt), .o_capture_value(capv), .o_capture_load(ld), .o_cc_out(cc),
    .o_irq(irq), .o_event_strobe(stb));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon transfer; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    do
      @(posedge clk);
    while (wq);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  // Wait up to 40 cycles for a pulse
  task automatic wait_hi(input int s);
    @(negedge clk);
    repeat (40)
      if (sig[s] !== 1'h1) @(negedge clk);
  endtask
  task automatic run_check(input int n, input logic [15:0] add);
    @(negedge clk);
    c0 = cnt;
    repeat (n) @(negedge clk);
    check(32'(cnt), 32'(c0 + add));
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'h0, 5'(i * 4), 8'h0);
      check(q, 32'h0);
    end
    foreach (rows[i])
    begin
      bus(1'h1, rows[i][20:16], rows[i][15:8]);
      bus(1'h0, rows[i][20:16], 8'h0);
      check(q, {24'h0, rows[i][7:0]});
    end
    $display("test registers done");
    bus(1'h1, 5'h18, 8'h01);
    bus(1'h1, 5'h00, 8'h01);
    @(negedge clk);
    run_check(1, 16'h1);
    bus(1'h1, 5'h00, 8'h03);
    run_check(4, 16'h2);
    bus(1'h1, 5'h00, 8'h15);
    run_check(4, 16'h0);
    @(posedge clk);
    rstrt <= 1'h1;
    @(posedge clk);
    rstrt <= 1'h0;
    repeat (3) @(negedge clk);
    check(32'(cnt), 32'h0);
    @(posedge clk);
    stby <= 1'h1;
    bus(1'h1, 5'h00, 8'h01);
    run_check(4, 16'h0);
    bus(1'h1, 5'h00, 8'h41);
    run_check(4, 16'h4);
    @(posedge clk);
    stby <= 1'h0;
    top <= 16'h0008;
    bus(1'h1, 5'h00, 8'h01);
    wait_hi(0);
    check(32'(irq), 32'h1);
    check(32'(stb), 32'h1);
    repeat (20) @(negedge clk);
    check(32'(irq), 32'h1);
    bus(1'h1, 5'h14, 8'h00);
    @(negedge clk);
    check(32'(irq), 32'h0);
    bus(1'h1, 5'h14, 8'h01);
    bus(1'h1, 5'h00, 8'h00);
    bus(1'h1, 5'h18, 8'h01);
    @(negedge clk);
    check(32'(irq), 32'h0);
    $display("test counting done");
    bus(1'h1, 5'h04, 8'h02);
    bus(1'h1, 5'h10, 8'h01);
    bus(1'h1, 5'h00, 8'h01);
    ev_lvl <= 1'h1;
    wait_hi(1);
    check(32'(ld), 32'h1);
    @(posedge clk);
    cap_rd <= 1'h1;
    @(posedge clk);
    cap_rd <= 1'h0;
    @(negedge clk);
    check(32'(irq), 32'h0);
    bus(1'h1, 5'h10, 8'h11);
    ev_lvl <= 1'h0;
    wait_hi(1);
    check(32'(ld), 32'h1);
    bus(1'h1, 5'h10, 8'h00);
    ev_lvl <= 1'h1;
    wait_hi(1);
    check(32'(ld), 32'h0);
    bus(1'h1, 5'h10, 8'h51);
    slow <= 1'h1;
    ev_lvl <= 1'h0;
    repeat (2) @(posedge clk);
    ev_lvl <= 1'h1;
    wait_hi(1);
    check(32'(ld), 32'h0);
    @(posedge clk);
    ev_lvl <= 1'h0;
    wait_hi(1);
    check(32'(ld), 32'h1);
    bus(1'h1, 5'h04, 8'h30);
    repeat (3) @(negedge clk);
    check(32'(cc), 32'h1);
    bus(1'h1, 5'h04, 8'h20);
    repeat (3) @(negedge clk);
    check(32'(cc), 32'h0);
    $display("test events done");
    // Mid-run reset brings registers and pin back to zero
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    bus(1'h0, 5'h04, 8'h0);
    check(q, 32'h0);
    check(32'(cc), 32'h0);
    $display("test reset done");
    summarize();
  end
endmodule // timer_b_control_status_tb
